// file: core/link_tx_defs.vh
// Constants for the transmit framing block of the serial converter link.
`ifndef LINK_TX_DEFS_VH
`define LINK_TX_DEFS_VH
`define MODE_F0          9'd2
`define MODE_K0          9'd32
`define MODE_F1          9'd4
`define MODE_K1          9'd16
`define MODE_F2          9'd8
`define MODE_K2          9'd32
`define MODE_F3          9'd1
`define MODE_K3          9'd32
`define K_MIN_NUM        18'd17
`define K_MAX_DIV        18'd1024
`define K_MAX_ABS        18'd256
`define ST_CGS           2'h0
`define ST_WAIT          2'h1
`define ST_ILAS          2'h2
`define ST_DATA          2'h3
`define ILAS_MF_LAST     2'h3
`define CHAR_K28_0       8'h1c
`define CHAR_K28_3       8'h7c
`define CHAR_K28_4       8'h9c
`define CHAR_K28_5       8'hbc
`define ILAS_POS_Q       18'h00001
`define ILAS_POS_F       18'h00002
`define ILAS_POS_K       18'h00003
`define ILAS_POS_CFG     18'h00004
`define SCR8_SEED        15'h7fff
`define SCR64_SEED       58'h3ffffffffffffff
`define SYNC_HDR_DATA    2'h1
`define BLOCK_LAST_OCTET 3'h7
`define FEAT_FEC         1'b1
`define FEAT_CRC3        1'b0
`define FEAT_CMD_CHAN    1'b0
`define FEAT_LINK_80     1'b0
`define FEAT_SUBCLASS    2'h1
`define FEAT_SYNC_PIN    1'b1
`define FEAT_LANE_ALIGN  1'b1
`define FEAT_MULTIREF    1'b0
`endif

// file: core/serial_link_tx_framing.v
// Transmit framing, scrambling, line coding and multiframe timing for two serial lanes.
`timescale 1ns/1ps
`include "link_tx_defs.vh"

// Notes on behaviour
// - Forward error correction is declared supported; the 64b/80b layer is absent.
// - No command channel is carried in the 64b/66b sync headers.
// - No CRC3 is generated in 64b/66b mode.
// - A physical active-low sync input is accepted in 8b/10b mode, level sensitive.
// - Operates as subclass 1 only, still usable with a subclass 0 receiver.
// - All lanes of one link align together; no multipoint reference alignment.
// - Samples are packed into octets, F octets per frame, frames spread over lanes.
// - Each 12-bit sample travels in a 16-bit container, one per lane every second cycle.
// - One mode select input picks the whole transport parameter set.
// - Frames form multiframes in 8b/10b, blocks and multiblocks in 64b/66b.
// - Scrambling is optional in 8b/10b and always on in 64b/66b.
// - The scramble enable input acts only in 8b/10b modes.
// - Octets are scrambled before 10-bit coding, blocks before the sync header.
// - The alignment sequence is never scrambled.
// - Separate scrambler polynomials are used for the two coding schemes.
// - Octets become DC-balanced 10-bit characters using running disparity.
// - K must lie between ceil(17/F) and min(256, floor(1024/F)).
// - A SYSREF rising edge resets the multiframe counter to phase zero.
// - The multiframe period is F times K characters, one character per clock.
// - While sync is low in 8b/10b mode every lane sends K28.5 commas; 64b/66b mode ignores sync.
// - After sync release an alignment sequence of four multiframes is sent.
// - Each scrambled 64-bit block gets a 2-bit sync header, making 66 bits.
module serial_link_tx_framing (
  // Clock and reset
  input  wire         clk_i,
  input  wire         nrst_i,
  // Configuration
  input  wire [1:0]   transport_mode_select_i,
  input  wire         scramble_enable_i,
  // Timing reference and handshake pins
  input  wire         sysref_i,
  input  wire         sync_n_i,
  // Sample stream, one 16-bit container per lane
  input  wire [31:0]  sample_i,
  output wire         sample_ready_o,
  // 8b/10b characters, ten bits per lane
  output wire [19:0]  char_o,
  output wire         char_valid_o,
  // 64b/66b blocks, 66 bits per lane
  output wire [131:0] block_o,
  output wire         block_valid_o,
  // Status
  output wire         lmfc_edge_o,
  output wire [1:0]   link_state_o,
  output wire         config_error_o,
  output wire         enc64_o,
  // Declared features
  output wire         feature_fec_o,
  output wire         feature_crc3_o,
  output wire         feature_cmd_chan_o,
  output wire         feature_link_80_o,
  output wire [1:0]   feature_subclass_o,
  output wire         feature_sync_pin_o,
  output wire         feature_lane_align_o,
  output wire         feature_multiref_o
);

  reg         sysref_meta_reg;
  reg         sysref_sync_reg;
  reg         sysref_prev_reg;
  reg         sync_meta_reg;
  reg         sync_n_reg;
  reg  [17:0] mf_cnt_reg;
  reg  [17:0] mf_cnt_next;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [1:0]  ilas_mf_reg;
  reg  [1:0]  ilas_mf_next;
  reg         byte_sel_reg;
  reg  [15:0] hold_reg;
  reg         lmfc_edge_reg;
  reg         cfg_err_reg;
  reg         enc64_reg;
  reg         char_valid_reg;
  reg         block_valid_reg;
  reg  [8:0]  f_val;
  reg  [8:0]  k_val;
  reg         enc64;
  reg  [17:0] k_lo;
  reg  [17:0] k_hi;
  reg         cfg_bad;
  reg  [7:0]  ilas_oct;
  reg         ilas_k;
  wire [17:0] fk;
  wire        sysref_edge;
  wire        lmfc_last;
  wire        scr_on;
  wire        block_last;

  // Scrambler with taps 15 and 14, octet processed most significant bit first.
  function [22:0] scr8;
    input [14:0] s;
    input [7:0]  d;
    integer      i;
    reg   [14:0] st;
    reg   [7:0]  o;
    begin
      st = s;
      o = 8'h00;
      for (i = 7; i >= 0; i = i - 1) begin
        o[i] = d[i] ^ st[14] ^ st[13];
        st = {st[13:0], o[i]};
      end
      scr8 = {st, o};
    end
  endfunction

  // Scrambler with taps 58 and 39 over a whole 64-bit block.
  function [121:0] scr64;
    input [57:0] s;
    input [63:0] d;
    integer      i;
    reg   [57:0] st;
    reg   [63:0] o;
    begin
      st = s;
      o = 64'h0;
      for (i = 63; i >= 0; i = i - 1) begin
        o[i] = d[i] ^ st[57] ^ st[38];
        st = {st[56:0], o[i]};
      end
      scr64 = {st, o};
    end
  endfunction

  // Encodes one octet to ten bits abcdeifghj and returns the new running disparity on top.
  function [10:0] enc;
    input [7:0] d;
    input       kf;
    input       rd;
    reg   [5:0] b6;
    reg   [3:0] b4;
    reg   [4:0] x;
    reg   [2:0] y;
    reg   [2:0] n6;
    reg         rdm;
    reg         unbal4;
    begin
      x = d[4:0];
      y = d[7:5];
      case (x)
        5'd0:  b6 = 6'b100111;
        5'd1:  b6 = 6'b011101;
        5'd2:  b6 = 6'b101101;
        5'd3:  b6 = 6'b110001;
        5'd4:  b6 = 6'b110101;
        5'd5:  b6 = 6'b101001;
        5'd6:  b6 = 6'b011001;
        5'd7:  b6 = 6'b111000;
        5'd8:  b6 = 6'b111001;
        5'd9:  b6 = 6'b100101;
        5'd10: b6 = 6'b010101;
        5'd11: b6 = 6'b110100;
        5'd12: b6 = 6'b001101;
        5'd13: b6 = 6'b101100;
        5'd14: b6 = 6'b011100;
        5'd15: b6 = 6'b010111;
        5'd16: b6 = 6'b011011;
        5'd17: b6 = 6'b100011;
        5'd18: b6 = 6'b010011;
        5'd19: b6 = 6'b110010;
        5'd20: b6 = 6'b001011;
        5'd21: b6 = 6'b101010;
        5'd22: b6 = 6'b011010;
        5'd23: b6 = 6'b111010;
        5'd24: b6 = 6'b110011;
        5'd25: b6 = 6'b100110;
        5'd26: b6 = 6'b010110;
        5'd27: b6 = 6'b110110;
        5'd28: b6 = 6'b001110;
        5'd29: b6 = 6'b101110;
        5'd30: b6 = 6'b011110;
        default: b6 = 6'b101011;
      endcase
      if (kf) begin
        b6 = 6'b001111;
      end
      n6 = b6[5] + b6[4] + b6[3] + b6[2] + b6[1] + b6[0];
      if (rd && ((n6 != 3'd3) || (x == 5'd7))) begin
        b6 = ~b6;
      end
      rdm = (n6 != 3'd3) ? ~rd : rd;
      case (y)
        3'd0:    b4 = 4'b1011;
        3'd1:    b4 = 4'b1001;
        3'd2:    b4 = 4'b0101;
        3'd3:    b4 = 4'b1100;
        3'd4:    b4 = 4'b1101;
        3'd5:    b4 = 4'b1010;
        3'd6:    b4 = 4'b0110;
        default: b4 = 4'b1110;
      endcase
      if (!kf && (y == 3'd7) && ((!rdm && ((x == 5'd17) || (x == 5'd18) || (x == 5'd20))) ||
          (rdm && ((x == 5'd11) || (x == 5'd13) || (x == 5'd14))))) begin
        b4 = 4'b0111;
      end
      unbal4 = (y == 3'd0) || (y == 3'd4) || (y == 3'd7);
      if (rdm && (unbal4 || (y == 3'd3))) begin
        b4 = ~b4;
      end else if (kf && !rdm && !unbal4 && (y != 3'd3)) begin
        b4 = ~b4;
      end
      enc = {(unbal4 ? ~rdm : rdm), b6, b4};
    end
  endfunction

  // Transport parameter sets chosen by the mode select input.
  always @* begin
    enc64 = 1'b0;
    case (transport_mode_select_i)
      2'h1: begin
        f_val = `MODE_F1;
        k_val = `MODE_K1;
      end
      2'h2: begin
        f_val = `MODE_F2;
        k_val = `MODE_K2;
        enc64 = 1'b1;
      end
      2'h3: begin
        f_val = `MODE_F3;
        k_val = `MODE_K3;
      end
      default: begin
        f_val = `MODE_F0;
        k_val = `MODE_K0;
      end
    endcase
    k_lo = (`K_MIN_NUM + {9'h0, f_val} - 18'd1) / {9'h0, f_val};
    k_hi = `K_MAX_DIV / {9'h0, f_val};
    if (k_hi > `K_MAX_ABS) begin
      k_hi = `K_MAX_ABS;
    end
    cfg_bad = ({9'h0, k_val} < k_lo) || ({9'h0, k_val} > k_hi);
  end

  assign fk          = f_val * k_val;
  assign sysref_edge = sysref_sync_reg & ~sysref_prev_reg;
  assign lmfc_last   = (mf_cnt_reg == fk - 18'd1);
  assign scr_on      = enc64 | scramble_enable_i;
  assign block_last  = (mf_cnt_reg[2:0] == `BLOCK_LAST_OCTET);

  // Multiframe counter and link state sequencing.
  always @* begin
    mf_cnt_next = lmfc_last ? 18'h0 : mf_cnt_reg + 18'd1;
    if (sysref_edge) begin
      mf_cnt_next = 18'h0;
    end
    state_next = state_reg;
    ilas_mf_next = ilas_mf_reg;
    case (state_reg)
      `ST_CGS: begin
        state_next = `ST_WAIT;
      end
      `ST_WAIT: begin
        if (lmfc_last) begin
          state_next = `ST_ILAS;
          ilas_mf_next = 2'h0;
        end
      end
      `ST_ILAS: begin
        if (lmfc_last) begin
          ilas_mf_next = ilas_mf_reg + 2'h1;
          if (ilas_mf_reg == `ILAS_MF_LAST) begin
            state_next = `ST_DATA;
          end
        end
      end
      `ST_DATA: begin
        state_next = `ST_DATA;
      end
      default: begin
        state_next = `ST_CGS;
      end
    endcase
    if (enc64) begin
      state_next = `ST_DATA;
    end else if (!sync_n_reg) begin
      state_next = `ST_CGS;
    end
  end

  // Alignment sequence content shared by all lanes, R and A mark each multiframe.
  always @* begin
    ilas_oct = mf_cnt_reg[7:0];
    ilas_k = 1'b0;
    if (mf_cnt_reg == 18'h0) begin
      ilas_oct = `CHAR_K28_0;
      ilas_k = 1'b1;
    end else if (lmfc_last) begin
      ilas_oct = `CHAR_K28_3;
      ilas_k = 1'b1;
    end else if (ilas_mf_reg == 2'h1) begin
      if (mf_cnt_reg == `ILAS_POS_Q) begin
        ilas_oct = `CHAR_K28_4;
        ilas_k = 1'b1;
      end else if (mf_cnt_reg == `ILAS_POS_F) begin
        ilas_oct = f_val[7:0] - 8'h01;
      end else if (mf_cnt_reg == `ILAS_POS_K) begin
        ilas_oct = k_val[7:0] - 8'h01;
      end else if (mf_cnt_reg == `ILAS_POS_CFG) begin
        ilas_oct = {scramble_enable_i, 5'h00, enc64, 1'b1};
      end
    end
  end

  // SYSREF and sync pins pass two flip-flops before use; shared control registers.
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sysref_meta_reg <= 1'b0;
      sysref_sync_reg <= 1'b0;
      sysref_prev_reg <= 1'b0;
      sync_meta_reg <= 1'b0;
      sync_n_reg <= 1'b0;
      mf_cnt_reg <= 18'h0;
      state_reg <= `ST_CGS;
      ilas_mf_reg <= 2'h0;
      byte_sel_reg <= 1'b0;
      hold_reg <= 16'h0;
      lmfc_edge_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
      enc64_reg <= 1'b0;
      char_valid_reg <= 1'b0;
      block_valid_reg <= 1'b0;
    end else begin
      sysref_meta_reg <= sysref_i;
      sysref_sync_reg <= sysref_meta_reg;
      sysref_prev_reg <= sysref_sync_reg;
      sync_meta_reg <= sync_n_i;
      sync_n_reg <= sync_meta_reg;
      mf_cnt_reg <= mf_cnt_next;
      state_reg <= state_next;
      ilas_mf_reg <= ilas_mf_next;
      byte_sel_reg <= (state_reg == `ST_DATA) ? ~byte_sel_reg : 1'b0;
      if (sample_ready_o) begin
        hold_reg <= {sample_i[23:16], sample_i[7:0]};
      end
      lmfc_edge_reg <= lmfc_last;
      cfg_err_reg <= cfg_bad;
      enc64_reg <= enc64;
      char_valid_reg <= ~enc64;
      block_valid_reg <= enc64 & block_last;
    end
  end

  // Per-lane octet packing, scrambling, 8b/10b coding and 64b/66b blocking.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : lane
      reg  [14:0]  s8_reg;
      reg  [57:0]  s64_reg;
      reg  [55:0]  blk_reg;
      reg          rd_reg;
      reg  [9:0]   code_reg;
      reg  [65:0]  out66_reg;
      reg  [7:0]   oct;
      reg          kch;
      wire [7:0]   raw;
      wire [22:0]  s8_res;
      wire [121:0] s64_res;
      wire [10:0]  enc_res;

      assign raw = byte_sel_reg ? hold_reg[g*8 +: 8] : sample_i[g*16+8 +: 8];
      assign s8_res = scr8(s8_reg, raw);
      assign s64_res = scr64(s64_reg, {blk_reg, raw});
      assign enc_res = enc(oct, kch, rd_reg);

      always @* begin
        oct = raw;
        kch = 1'b0;
        case (state_reg)
          `ST_ILAS: begin
            oct = ilas_oct;
            kch = ilas_k;
          end
          `ST_DATA: begin
            oct = scr_on ? s8_res[7:0] : raw;
          end
          default: begin
            oct = `CHAR_K28_5;
            kch = 1'b1;
          end
        endcase
      end

      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          s8_reg <= `SCR8_SEED;
          s64_reg <= `SCR64_SEED;
          blk_reg <= 56'h0;
          rd_reg <= 1'b0;
          code_reg <= 10'h0;
          out66_reg <= 66'h0;
        end else begin
          if (!enc64) begin
            code_reg <= enc_res[9:0];
            rd_reg <= enc_res[10];
            if ((state_reg == `ST_DATA) && scramble_enable_i) begin
              s8_reg <= s8_res[22:8];
            end
          end else begin
            blk_reg <= {blk_reg[47:0], raw};
            if (block_last) begin
              s64_reg <= s64_res[121:64];
              out66_reg <= {`SYNC_HDR_DATA, s64_res[63:0]};
            end
          end
        end
      end

      assign char_o[g*10 +: 10] = code_reg;
      assign block_o[g*66 +: 66] = out66_reg;
    end
  endgenerate

  assign sample_ready_o       = (state_reg == `ST_DATA) & ~byte_sel_reg;
  assign char_valid_o         = char_valid_reg;
  assign block_valid_o        = block_valid_reg;
  assign lmfc_edge_o          = lmfc_edge_reg;
  assign link_state_o         = state_reg;
  assign config_error_o       = cfg_err_reg;
  assign enc64_o              = enc64_reg;
  assign feature_fec_o        = `FEAT_FEC;
  assign feature_crc3_o       = `FEAT_CRC3;
  assign feature_cmd_chan_o   = `FEAT_CMD_CHAN;
  assign feature_link_80_o    = `FEAT_LINK_80;
  assign feature_subclass_o   = `FEAT_SUBCLASS;
  assign feature_sync_pin_o   = `FEAT_SYNC_PIN;
  assign feature_lane_align_o = `FEAT_LANE_ALIGN;
  assign feature_multiref_o   = `FEAT_MULTIREF;

endmodule

// file: bench/link_tx_checker_assertions.sv
// Port checks for the transmit framing block.
`timescale 1ns/1ps
module link_tx_checker (
  // Clock, reset and pins
  input wire         clk_i,
  input wire         nrst_i,
  input wire [1:0]   transport_mode_select_i,
  input wire         sysref_i,
  input wire         sync_n_i,
  // Outputs under watch
  input wire         sample_ready_o,
  input wire [19:0]  char_o,
  input wire         char_valid_o,
  input wire [131:0] block_o,
  input wire         block_valid_o,
  input wire         lmfc_edge_o,
  input wire [1:0]   link_state_o,
  input wire         config_error_o,
  input wire         enc64_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  reg  [9:0] cnt_reg;
  reg  [9:0] src_reg;
  reg        sr_reg;
  reg        seen_reg;
  reg        live_reg;
  // Multiframe length in clocks for the selected mode.
  wire [9:0] per = (transport_mode_select_i == 2'h2) ? 10'h100 :
                   (transport_mode_select_i == 2'h3) ? 10'h020 : 10'h040;
  wire       rise = sysref_i & ~sr_reg;
  wire       old = src_reg > 10'h005;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg  <= 10'h000;
      src_reg  <= 10'h3ff;
      sr_reg   <= 1'b0;
      seen_reg <= 1'b0;
      live_reg <= 1'b0;
    end else begin
      cnt_reg  <= lmfc_edge_o ? 10'h000 : cnt_reg + 10'h001;
      src_reg  <= rise ? 10'h000 : src_reg + {9'h000, src_reg != 10'h3ff};
      sr_reg   <= sysref_i;
      seen_reg <= rise | (seen_reg & ~(lmfc_edge_o & old));
      live_reg <= live_reg | lmfc_edge_o;
    end
  end
  a_cfg_in_range: assert property (!config_error_o)
    else $error("config error in a built-in mode");
  a_ready_paced: assert property (
    sample_ready_o |-> link_state_o == 2'h3 ##1 !sample_ready_o)
    else $error("sample ready outside data or held");
  a_ready_resumes: assert property (
    (link_state_o == 2'h3 && !sample_ready_o) ##1 link_state_o == 2'h3 |-> sample_ready_o)
    else $error("sample ready skipped a pair");
  a_char_vs_block: assert property (enc64_o |-> !char_valid_o)
    else $error("characters valid in block mode");
  a_sync_to_cgs: assert property (
    $fell(sync_n_i) && !enc64_o |-> ##[1:4] link_state_o == 2'h0)
    else $error("sync low did not restart");
  a_cgs_commas: assert property (
    link_state_o == 2'h0 && char_valid_o |=>
    (char_o[9:0] == 10'h0fa || char_o[9:0] == 10'h305) &&
    (char_o[19:10] == 10'h0fa || char_o[19:10] == 10'h305))
    else $error("no comma during sync request");
  a_ilas_opens: assert property (
    link_state_o == 2'h2 && $past(link_state_o) == 2'h1 |->
    ##[0:1] (char_o[9:0] == 10'h0f4 || char_o[9:0] == 10'h30b))
    else $error("alignment sequence did not open");
  a_block_cadence: assert property (
    block_valid_o |=> !block_valid_o [*7] ##1 block_valid_o)
    else $error("block not every eighth clock");
  a_sync_header: assert property (
    block_valid_o |-> block_o[65:64] == 2'h1 && block_o[131:130] == 2'h1)
    else $error("bad block header");
  a_lmfc_period: assert property (
    lmfc_edge_o && live_reg && !seen_reg |-> cnt_reg == per - 10'h001)
    else $error("multiframe period wrong");
  a_sysref_phase: assert property (
    lmfc_edge_o && seen_reg && old |-> src_reg >= per + 10'h002 && src_reg <= per + 10'h006)
    else $error("multiframe not realigned");
  c_ilas_to_data: cover property (link_state_o == 2'h2 ##1 link_state_o == 2'h3);
  c_block: cover property (block_valid_o);
  c_realign: cover property (lmfc_edge_o && seen_reg && old);
endmodule
bind serial_link_tx_framing link_tx_checker i_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .transport_mode_select_i(transport_mode_select_i),
  .sysref_i(sysref_i), .sync_n_i(sync_n_i), .sample_ready_o(sample_ready_o),
  .char_o(char_o), .char_valid_o(char_valid_o), .block_o(block_o),
  .block_valid_o(block_valid_o), .lmfc_edge_o(lmfc_edge_o), .link_state_o(link_state_o),
  .config_error_o(config_error_o), .enc64_o(enc64_o));

// file: bench/link_rx_model.sv
// Receiver model that drives the active-low sync pin from the comma count.
`timescale 1ns/1ps
module link_rx_model (
  // Clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // Transmitter side and bench command
  input  wire [19:0] char_i,
  input  wire        lmfc_edge_i,
  input  wire        hold_i,
  // Sync pin
  output wire        sync_n_o
);
  reg  [2:0] commas_reg;
  reg        sync_n_reg;
  wire       comma = char_i[9:0] == 10'h0fa || char_i[9:0] == 10'h305;
  assign sync_n_o = sync_n_reg;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      commas_reg <= 3'h0;
      sync_n_reg <= 1'b0;
    end else if (hold_i) begin
      commas_reg <= 3'h0;
      sync_n_reg <= 1'b0;
    end else if (!sync_n_reg) begin
      commas_reg <= !comma ? 3'h0 : (commas_reg == 3'h4) ? 3'h4 : commas_reg + 3'h1;
      sync_n_reg <= commas_reg == 3'h4 && lmfc_edge_i;
    end
  end
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the transmit framing block.
`timescale 1ns/1ps
module tb_top;
  reg          clk_i = 1'b0;
  reg          nrst_i = 1'b0;
  reg  [1:0]   mode = 2'h0;
  reg          scramble_enable = 1'b0;
  reg          sysref = 1'b0;
  reg          hold = 1'b0;
  reg          mon = 1'b0;
  reg  [31:0]  sample = 32'h0;
  reg  [7:0]   sref_cnt = 8'h00;
  reg  [15:0]  rnd = 16'h0031;
  reg  [19:0]  rec [0:1][0:31];
  reg  [131:0] dat [0:1][0:31];
  reg          same_i, same_d;
  integer      ilas_n [0:1];
  integer      rd [0:1];
  integer      err_total = 0;
  integer      comparisons = 0;
  integer      m, k, j;
  wire         sync_n, ready, cvalid, bvalid, lmfc, cerr, enc64;
  wire [19:0]  chr;
  wire [131:0] blk;
  wire [1:0]   state;
  wire [8:0]   feat;
  serial_link_tx_framing i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .transport_mode_select_i(mode),
    .scramble_enable_i(scramble_enable), .sysref_i(sysref), .sync_n_i(sync_n), .sample_i(sample),
    .sample_ready_o(ready), .char_o(chr), .char_valid_o(cvalid), .block_o(blk),
    .block_valid_o(bvalid), .lmfc_edge_o(lmfc), .link_state_o(state),
    .config_error_o(cerr), .enc64_o(enc64), .feature_fec_o(feat[8]),
    .feature_crc3_o(feat[7]), .feature_cmd_chan_o(feat[6]), .feature_link_80_o(feat[5]),
    .feature_subclass_o(feat[4:3]), .feature_sync_pin_o(feat[2]),
    .feature_lane_align_o(feat[1]), .feature_multiref_o(feat[0]));
  link_rx_model i_rx (.clk_i(clk_i), .nrst_i(nrst_i), .char_i(chr), .lmfc_edge_i(lmfc),
    .hold_i(hold), .sync_n_o(sync_n));
  always #2.5 clk_i = ~clk_i;
  function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function [31:0] per(input [1:0] x);
    per = (x == 2'h2) ? 32'd256 : (x == 2'h3) ? 32'd32 : 32'd64;
  endfunction
  // Running disparity after one character; 9 marks an illegal character.
  function integer step(input [9:0] c, input integer r);
    integer ones;
    begin
      ones = $countones(c);
      if (ones == 5) step = r;
      else if (ones == 6 && r <= 0) step = 1;
      else if (ones == 4 && r >= 0) step = -1;
      else step = 9;
    end
  endfunction
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task results;
    begin
      $display("Comparisons %0d, errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  // Periodic timing reference at a multiple of every multiframe length.
  // It stays low until the monitor starts, so every rise keeps one fixed phase.
  always @(negedge clk_i) begin
    sref_cnt <= mon ? sref_cnt + 8'h01 : 8'h00;
    sysref   <= mon && (sref_cnt < 8'h04);
    rnd      <= mon ? lfsr(rnd) : 16'h0031;
    sample   <= mon ? {lfsr(rnd), rnd} : 32'h0;
  end
  always @(negedge clk_i) begin
    for (j = 0; j < 2; j = j + 1) begin
      if (!mon) rd[j] = 0;
      else if (cvalid === 1'b1) begin
        rd[j] = step(chr[j*10 +: 10], rd[j]);
        chk("running disparity", 32'h1, {31'h0, rd[j] != 9});
        if (rd[j] == 9) rd[j] = 0;
      end
    end
  end
  task run(input [1:0] mm, input s);
    integer i, n;
    begin
      @(posedge clk_i);
      mon = 1'b0;
      @(negedge clk_i);
      nrst_i = 1'b0;
      mode = mm;
      scramble_enable = s;
      hold = 1'b0;
      ilas_n[s] = 0;
      n = 0;
      for (i = 0; i < 32; i = i + 1) dat[s][i] = 132'h0;
      repeat (6) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      mon = 1'b1;
      @(negedge clk_i);
      chk("features", 32'h10e, {23'h0, feat});
      chk("block mode flag", {31'h0, mm == 2'h2}, {31'h0, enc64});
      chk("config error", 32'h0, {31'h0, cerr});
      i = 0;
      while (state !== 2'h3 && i < 3000) begin
        if (state === 2'h2) begin
          if (ilas_n[s] < 32) rec[s][ilas_n[s]] = chr;
          ilas_n[s] = ilas_n[s] + 1;
        end
        @(negedge clk_i);
        i = i + 1;
      end
      if (i == 3000) begin
        err_total = err_total + 1;
        $display("ERROR link state expected 3 seen %h", state);
        results;
      end
      if (mm != 2'h2) chk("ilas length", 4 * per(mm), ilas_n[s]);
      for (i = 0; i < 32; i = i + 1) begin
        if (bvalid === 1'b1) begin
          chk("sync headers", 32'h5, {28'h0, blk[131:130], blk[65:64]});
          dat[s][n] = blk;
          n = n + 1;
        end else if (cvalid === 1'b1) dat[s][i] = {112'h0, chr};
        @(negedge clk_i);
      end
      hold = 1'b1;
      repeat (8) @(negedge clk_i);
      chk("state with sync low", (mm == 2'h2) ? 32'h3 : 32'h0, {30'h0, state});
      if (mm != 2'h2) chk("comma", 32'h1, {31'h0, chr[9:0] == 10'h0fa || chr[9:0] == 10'h305});
    end
  endtask
  initial begin
    for (m = 0; m < 4; m = m + 1) begin
      run(m[1:0], 1'b0);
      run(m[1:0], 1'b1);
      same_i = 1'b1;
      same_d = 1'b1;
      for (k = 0; k < 32; k = k + 1) begin
        if (rec[0][k] !== rec[1][k]) same_i = 1'b0;
        if (dat[0][k] !== dat[1][k]) same_d = 1'b0;
      end
      if (m == 2) chk("blocks ignore enable", 32'h1, {31'h0, same_d});
      else begin
        chk("ilas unscrambled", 32'h1, {31'h0, same_i});
        chk("data scrambled", 32'h0, {31'h0, same_d});
      end
    end
    results;
  end
endmodule
